// file: pkg/cif_pkg.sv
// shared constants and carriers for the can interrupt / fifo status block
package cif_pkg;

	// register byte offsets (one aligned 32-bit word each)
	localparam logic [4:0] OFS_FLT_LEN = 5'h00;
	localparam logic [4:0] OFS_VEC     = 5'h04;
	localparam logic [4:0] OFS_FCTRL   = 5'h08;
	localparam logic [4:0] OFS_FIFO    = 5'h0C;
	localparam logic [4:0] OFS_INTF    = 5'h10;
	localparam logic [4:0] OFS_INTE    = 5'h14;

	// field positions
	localparam int HIT_LSB    = 8;   // matched filter number in vector reg
	localparam int BS_LSB     = 13;  // buffer count code in fifo config
	localparam int WPTR_LSB   = 8;   // write pointer in fifo status
	localparam int ERR_LSB    = 8;   // error state bits in flag reg
	localparam int IF_TX      = 0;
	localparam int IF_RX      = 1;
	localparam int IF_OVF     = 2;
	localparam int IF_FIFO    = 3;
	localparam int IF_ERR     = 5;
	localparam int IF_WAK     = 6;
	localparam int IF_IVR     = 7;

	// implemented flag / enable bits (bit 4 is a hole)
	localparam logic [7:0] FLAG_MASK = 8'hEF;

	// reset values
	localparam logic [4:0] RST_FLT_LEN = 5'h00;
	localparam logic [2:0] RST_BS      = 3'h0;
	localparam logic [4:0] RST_START   = 5'h00;
	localparam logic [5:0] RST_PTR     = 6'h00;
	localparam logic [7:0] RST_FLAGS   = 8'h00;
	localparam logic [7:0] RST_ENABLES = 8'h00;

	// filter length limits and buffer count codes
	localparam logic [4:0] FLT_LEN_MAX = 5'h11;
	localparam logic [2:0] BS_RSVD     = 3'h7;

	// interrupt source codes
	localparam logic [6:0] IC_NONE = 7'h40;
	localparam logic [6:0] IC_ERR  = 7'h41;
	localparam logic [6:0] IC_WAK  = 7'h42;
	localparam logic [6:0] IC_OVF  = 7'h43;
	localparam logic [6:0] IC_FIFO = 7'h44;

	// event pulses from the protocol engine and message buffer side
	typedef struct packed {
		logic       tx_done;      // a transmit buffer finished
		logic [2:0] tx_idx;       // which tx_rx_buffer
		logic       rx_done;      // a message was stored
		logic [3:0] rx_idx;       // which buffer it went to
		logic [3:0] rx_hit;       // matched_filter_number of it
		logic       invalid;      // invalid message seen
		logic       wakeup;       // bus wake-up activity
		logic       overflow;     // receive buffer overflowed
		logic       almost_full;  // fifo reached almost full
		logic       fifo_write;   // message written at write pointer
		logic       fifo_read;    // software consumed read pointer buffer
	} cif_evt_t;

	// error state levels from the error counters
	typedef struct packed {
		logic tx_bus_off;
		logic tx_error_passive;
		logic rx_error_passive;
		logic tx_error_warning;
		logic rx_error_warning;
	} cif_err_t;

endpackage : cif_pkg

// file: verilog/cif_status.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module cif_status
	import cif_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// protocol engine side
	input  wire cif_evt_t    evt,
	input  wire cif_err_t    err_state,
	// identifier-extension payload filter
	input  wire logic [17:0] flt_eid,
	input  wire logic [23:0] flt_data,
	output logic             flt_data_match
);

	// register storage
	logic [4:0]  flt_len_q;    // data_filter_bit_count
	logic [3:0]  hit_q;        // matched_filter_number
	logic [6:0]  code_q;       // interrupt_source_code
	logic [2:0]  bs_q;         // dma_buffer_count code
	logic [4:0]  start_q;      // fifo_start_buffer
	logic [5:0]  wptr_q;       // fifo_write_pointer
	logic [5:0]  rptr_q;       // fifo_read_pointer
	logic [5:0]  err_q;        // mirrored error state, bit 0 combined
	logic [5:0]  err_prev_q;   // last cycle's state for edge detect
	logic [7:0]  flags_q;      // interrupt flags
	logic [7:0]  flags_d;
	logic [7:0]  en_q;         // interrupt enables
	logic [2:0]  tx_idx_q;     // last finished tx buffer
	logic [3:0]  rx_idx_q;     // last filled rx buffer
	logic [31:0] rdata_d;      // read mux

	// bus access decode
	logic        wr_ack;       // write takes effect this edge
	logic [15:0] wmask;        // byte lanes 0 and 1 as a bit mask
	logic [15:0] wval;         // lane-merged write data
	logic [5:0]  err_now;      // live error state, combined bit low

	// widen byte enables of the low half-word into a bit mask
	// lanes 2 and 3 have no storage behind them, so they are ignored
	function automatic logic [15:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// buffer count from the size code; reserved code never stored
	// code 6 falls into the default and gives the largest area
	function automatic logic [5:0] buf_count(input logic [2:0] c);
		unique case (c)
			3'h0: buf_count = 6'h04;
			3'h1: buf_count = 6'h06;
			3'h2: buf_count = 6'h08;
			3'h3: buf_count = 6'h0C;
			3'h4: buf_count = 6'h10;
			3'h5: buf_count = 6'h18;
			default: buf_count = 6'h20;
		endcase
	endfunction : buf_count

	// step a fifo pointer, wrapping to the start of the fifo area
	function automatic logic [5:0] ptr_step(input logic [5:0] p,
		input logic [4:0] s, input logic [2:0] c);
		logic [5:0] nxt;
		nxt = p + 6'h01;
		// a start past the end of memory leaves a one-slot area
		if (nxt >= buf_count(c)) begin
			ptr_step = {1'b0, s};
		end else begin
			ptr_step = nxt;
		end
	endfunction : ptr_step

	// payload bits in compare order: byte1 bit7 first
	function automatic logic payload_ok(input logic [4:0] n,
		input logic [17:0] extended_identifier, input logic [23:0] data);
		logic ok;
		ok = 1'b1;
		// the top legal code reaches the last identifier bit as well, so
		// it compares all eighteen bits rather than seventeen
		for (int k = 0; k < 18; k++) begin
			if (5'(k) < n || n == FLT_LEN_MAX) begin
				ok = ok & (data[23 - k] == extended_identifier[k]);
			end
		end
		payload_ok = ok;
	endfunction : payload_ok

	// a write lands only on the edge where the master sees waitrequest
	// low; every register sits in the low half-word
	assign wr_ack = avs_write & ~avs_waitrequest;
	assign wmask  = lane_mask(avs_byteenable);
	assign wval   = avs_writedata[15:0] & wmask;
	// combined warning follows either direction's warning
	// bus-off and passive states do not feed the combined bit
	assign err_now = {err_state.tx_bus_off, err_state.tx_error_passive,
		err_state.rx_error_passive, err_state.tx_error_warning,
		err_state.rx_error_warning,
		err_state.tx_error_warning | err_state.rx_error_warning};

	// wait state: every access is answered on the second edge
	// one fixed wait cycle keeps the read mux off the bus path and
	// gives every access the same two-edge shape
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			// drop for exactly one cycle, then rearm for the next access
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
		end
	end

	// read data is captured as waitrequest falls, unmapped reads zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (avs_address)
			// filter length in the low five bits
			OFS_FLT_LEN: rdata_d[4:0] = flt_len_q;
			// hit number above, source code below
			OFS_VEC: begin
				rdata_d[HIT_LSB +: 5] = {1'b0, hit_q};
				rdata_d[6:0]          = code_q;
			end
			// bits 12 to 5 stay zero
			OFS_FCTRL: begin
				rdata_d[BS_LSB +: 3] = bs_q;
				rdata_d[4:0]         = start_q;
			end
			// both pointers, top two bits of each byte zero
			OFS_FIFO: begin
				rdata_d[WPTR_LSB +: 6] = wptr_q;
				rdata_d[5:0]           = rptr_q;
			end
			// error state above, flags below
			OFS_INTF: begin
				rdata_d[ERR_LSB +: 6] = err_q;
				rdata_d[7:0]          = flags_q;
			end
			OFS_INTE: rdata_d[7:0] = en_q;
			// unmapped offsets read zero
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// read data register, loaded on the taken edge only, so the value
	// stands still until the master samples it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & avs_waitrequest) begin
			avs_readdata <= rdata_d;
		end
	end

	// filter length setting; invalid codes are refused
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_len_q <= RST_FLT_LEN;
		end else if (wr_ack && avs_address == OFS_FLT_LEN && wmask[0]
			&& wval[4:0] <= FLT_LEN_MAX) begin
			// a refused code leaves the previous length in place
			// guards the compare against a software slip
			flt_len_q <= wval[4:0];
		end
	end

	// payload compare result, registered for the acceptance logic
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_data_match <= 1'b1;
		end else if (flt_len_q == 5'h00) begin
			// no payload bit takes part at length zero
			flt_data_match <= 1'b1;
		end else begin
			// compare the selected payload bits in order
			flt_data_match <= payload_ok(flt_len_q, flt_eid, flt_data);
		end
	end

	// fifo configuration, only the implemented fields are stored
	// size code sits in byte lane 1, start buffer in lane 0
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bs_q    <= RST_BS;
			start_q <= RST_START;
		end else if (wr_ack && avs_address == OFS_FCTRL) begin
			// reserved size code leaves the old size in place
			if (wmask[15] && wval[BS_LSB +: 3] != BS_RSVD) begin
				bs_q <= wval[BS_LSB +: 3];
			end
			if (wmask[0]) begin
				start_q <= wval[4:0];
			end
		end
	end

	// write pointer follows stored messages through the fifo area
	// a reload and an event in one cycle: the reload wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wptr_q <= RST_PTR;
		end else if (wr_ack && avs_address == OFS_FCTRL && wmask[0]) begin
			// writing the start buffer restarts the ring
			wptr_q <= {1'b0, wval[4:0]};
		end else if (evt.fifo_write) begin
			wptr_q <= ptr_step(wptr_q, start_q, bs_q);
		end
	end

	// read pointer follows buffers consumed by software
	// same ring rule as the write pointer, so both wrap alike
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rptr_q <= RST_PTR;
		end else if (wr_ack && avs_address == OFS_FCTRL && wmask[0]) begin
			rptr_q <= {1'b0, wval[4:0]};
		end else if (evt.fifo_read) begin
			rptr_q <= ptr_step(rptr_q, start_q, bs_q);
		end
	end

	// error state mirror and its previous value for edge detect
	// both reset low like the idle engine, so no false edge follows
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_q      <= 6'h00;
			err_prev_q <= 6'h00;
		end else begin
			err_q      <= err_now;
			err_prev_q <= err_q;
		end
	end

	// flags: software writes zero to clear, hardware set wins
	always_comb begin
		flags_d = flags_q;
		if (wr_ack && avs_address == OFS_INTF && wmask[0]) begin
			flags_d = flags_q & wval[7:0];
		end
		// set after clear so a same-cycle event is not lost
		flags_d[IF_TX]   = flags_d[IF_TX] | evt.tx_done;
		flags_d[IF_RX]   = flags_d[IF_RX] | evt.rx_done;
		flags_d[IF_OVF]  = flags_d[IF_OVF] | evt.overflow;
		flags_d[IF_FIFO] = flags_d[IF_FIFO] | evt.almost_full;
		// any newly entered error state raises the error flag
		flags_d[IF_ERR]  = flags_d[IF_ERR] | (|(err_q & ~err_prev_q));
		flags_d[IF_WAK]  = flags_d[IF_WAK] | evt.wakeup;
		flags_d[IF_IVR]  = flags_d[IF_IVR] | evt.invalid;
		// the hole at bit 4 can never hold a one
		flags_d          = flags_d & FLAG_MASK;
	end

	// flag register; clears and sets are already merged in flags_d
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= RST_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// enables share the flag bit positions
	// plain storage; the gating happens in the source code logic
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= RST_ENABLES;
		end else if (wr_ack && avs_address == OFS_INTE && wmask[0]) begin
			en_q <= wval[7:0] & FLAG_MASK;
		end
	end

	// last buffer indices and the filter that matched
	// the hit number always belongs to the last stored message
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_idx_q <= 3'h0;
			rx_idx_q <= 4'h0;
			hit_q    <= 4'h0;
		end else begin
			if (evt.tx_done) begin
				tx_idx_q <= evt.tx_idx;
			end
			if (evt.rx_done) begin
				rx_idx_q <= evt.rx_idx;
				hit_q    <= evt.rx_hit;
			end
		end
	end

	// single reported source; only one buffer index is kept per
	// direction, so within a direction the most recent buffer event is the one shown
	// the code lags the flags by one edge, so a flag may be seen one
	// read before its code
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			code_q <= IC_NONE;
		end else begin
			if (flags_q[IF_ERR] & en_q[IF_ERR]) begin
				code_q <= IC_ERR;
			end else if (flags_q[IF_OVF] & en_q[IF_OVF]) begin
				code_q <= IC_OVF;
			end else if (flags_q[IF_WAK] & en_q[IF_WAK]) begin
				code_q <= IC_WAK;
			end else if (flags_q[IF_FIFO] & en_q[IF_FIFO]) begin
				code_q <= IC_FIFO;
			end else if (flags_q[IF_RX] & en_q[IF_RX]) begin
				code_q <= {3'h0, rx_idx_q};
			end else if (flags_q[IF_TX] & en_q[IF_TX]) begin
				code_q <= {4'h0, tx_idx_q};
			end else begin
				// indices never exceed 15, so no reserved code appears
				code_q <= IC_NONE;
			end
		end
	end

endmodule : cif_status

// file: sim/cif_engine_model.sv
`timescale 1ns/1ps
// stand-in for the protocol engine beside the status block
module cif_engine_model
	import cif_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// engine outputs
	output cif_evt_t         evt,
	output cif_err_t         err_state,
	output logic      [17:0] flt_eid,
	output logic      [23:0] flt_data
);
	// quiet engine at time zero
	initial begin
		evt = '0;
		err_state = '0;
		flt_eid = '0;
		flt_data = '0;
	end
	// one-cycle event pulse, then a quiet cycle so pulses never merge
	task automatic pulse(input cif_evt_t e);
		evt <= e;
		@(posedge core_clk);
		evt <= '0;
		@(posedge core_clk);
	endtask : pulse
	// new error state levels, seen from the next edge on
	task automatic set_err(input cif_err_t e);
		err_state <= e;
	endtask : set_err
	// new identifier and payload for the filter compare
	task automatic set_payload(input logic [17:0] id,
		input logic [23:0] d);
		flt_eid  <= id;
		flt_data <= d;
	endtask : set_payload
endmodule : cif_engine_model

// file: sim/cif_status_checker.sv
`timescale 1ns/1ps
// bus timing and field range checks at the register port
module cif_status_checker
	import cif_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        arst_n,
	// avalon-mm slave
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// request seen while the slave still holds it off
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	// edge where the master takes read data of one address
	sequence s_rd(logic [4:0] a);
		avs_read && !avs_waitrequest && avs_address == a;
	endsequence
	wait_one_a: assert property (s_take |=> !avs_waitrequest ##1
		avs_waitrequest) else $error("wait cycle count wrong");
	upper_zero_a: assert property (avs_readdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	code_range_a: assert property (s_rd(OFS_VEC) |->
		(avs_readdata[6:0] <= 7'h0F || (avs_readdata[6:0] >= IC_NONE &&
		avs_readdata[6:0] <= IC_FIFO))) else $error("reserved code");
	hit_range_a: assert property (s_rd(OFS_VEC) |->
		avs_readdata[15:12] == 4'h0 && !avs_readdata[7])
		else $error("hit number out of range");
	fctrl_hole_a: assert property (s_rd(OFS_FCTRL) |->
		avs_readdata[12:5] == 8'h0 && avs_readdata[15:13] != BS_RSVD)
		else $error("fifo config field wrong");
	fifo_ptr_a: assert property (s_rd(OFS_FIFO) |->
		avs_readdata[15:13] == 3'h0 && avs_readdata[7:5] == 3'h0)
		else $error("pointer out of range");
	flag_warn_a: assert property (s_rd(OFS_INTF) |->
		avs_readdata[8] == (avs_readdata[10] | avs_readdata[9]) &&
		avs_readdata[15:14] == 2'h0 && !avs_readdata[4]) else $error("warn");
	len_legal_a: assert property (s_rd(OFS_FLT_LEN) |->
		avs_readdata[15:5] == 11'h0 && avs_readdata[4:0] <= FLT_LEN_MAX)
		else $error("filter length wrong");
	unmapped_a: assert property (avs_read && !avs_waitrequest &&
		avs_address > OFS_INTE |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
endmodule : cif_status_checker

bind cif_status cif_status_checker chk_u (
	.core_clk       (core_clk),
	.arst_n         (arst_n),
	.avs_address    (avs_address),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest)
);

// file: sim/cif_status_tb.sv
`timescale 1ns/1ps
module cif_status_tb
	import cif_pkg::*;
();
	// clock, reset and master side
	logic        core_clk;
	logic        arst_n;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        flt_data_match;
	// engine side, driven by the model
	cif_evt_t    evt;
	cif_err_t    err_state;
	logic [17:0] flt_eid;
	logic [23:0] flt_data;
	// tallies and scratch
	int          bad_count;
	int          compares;
	int          i;
	logic [31:0] q;
	// flag cleared per step and the code expected after it
	int          clr [5] = '{5, 2, 6, 3, 0};
	logic [31:0] code [5] = '{32'h43, 32'h42, 32'h44, 32'h07, 32'h40};

	cif_status dut_u (
		.core_clk       (core_clk),
		.arst_n         (arst_n),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (avs_byteenable),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.evt            (evt),
		.err_state      (err_state),
		.flt_eid        (flt_eid),
		.flt_data       (flt_data),
		.flt_data_match (flt_data_match)
	);
	cif_engine_model pe_u (
		.core_clk (core_clk),
		.evt      (evt),
		.err_state(err_state),
		.flt_eid  (flt_eid),
		.flt_data (flt_data)
	);

	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// compare one value and tally it
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	// one access, held until waitrequest is sampled low; bounded wait
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// idle edge so the next request is a fresh assignment
		@(posedge core_clk);
	endtask : acc
	// read and compare
	task automatic rdc(input string nm, input logic [4:0] a,
		input logic [31:0] e);
		acc(1'b0, a, 32'h0, 4'hF);
		chk(nm, e, q);
	endtask : rdc
	// counts, verdict, end of run
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict
	// hang guard, far beyond the roughly 160 cycles the tests need
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		give_verdict();
	end
	// main sequence
	initial begin
		arst_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rdc("reset", 5'(i * 4), i == 1 ? 32'h40 : 32'h0);
		end
		$display("test reset done");
		// payload filter: refused code, length zero, length one
		acc(1'b1, OFS_FLT_LEN, 32'h12, 4'hF);
		rdc("len_bad", OFS_FLT_LEN, 32'h0);
		pe_u.set_payload(18'h00000, 24'h800000);
		repeat (2) @(posedge core_clk);
		chk("match_len0", 32'h1, 32'(flt_data_match));
		acc(1'b1, OFS_FLT_LEN, 32'h1, 4'hF);
		// the compare result lands one edge after the length
		@(posedge core_clk);
		chk("match_len1", 32'h0, 32'(flt_data_match));
		pe_u.set_payload(18'h00000, 24'h400000);
		repeat (2) @(posedge core_clk);
		chk("match_k1", 32'h1, 32'(flt_data_match));
		// top code reaches identifier bit 17 against byte 3 bit 6
		acc(1'b1, OFS_FLT_LEN, 32'h11, 4'hF);
		pe_u.set_payload(18'h20000, 24'h000000);
		repeat (2) @(posedge core_clk);
		chk("match_top0", 32'h0, 32'(flt_data_match));
		pe_u.set_payload(18'h20000, 24'h000040);
		repeat (2) @(posedge core_clk);
		chk("match_top1", 32'h1, 32'(flt_data_match));
		$display("test filter done");
		// fifo config, pointers, byte lane
		acc(1'b1, OFS_FCTRL, 32'hFFE3, 4'hF);
		rdc("fctrl_rsvd", OFS_FCTRL, 32'h3);
		acc(1'b1, OFS_FCTRL, 32'h2, 4'hF);
		rdc("fifo_start", OFS_FIFO, 32'h202);
		pe_u.pulse(cif_evt_t'{fifo_write:1'b1, default:'0});
		pe_u.pulse(cif_evt_t'{fifo_write:1'b1, default:'0});
		pe_u.pulse(cif_evt_t'{fifo_read:1'b1, default:'0});
		rdc("fifo_step", OFS_FIFO, 32'h203);
		acc(1'b1, OFS_FCTRL, 32'hC0FF, 4'h2);
		rdc("fctrl_lane", OFS_FCTRL, 32'hC002);
		$display("test fifo done");
		// flags, codes and priority
		acc(1'b1, OFS_INTE, 32'hFFFF, 4'hF);
		rdc("enables", OFS_INTE, 32'hEF);
		pe_u.pulse(cif_evt_t'{rx_done:1'b1, rx_idx:4'h9, rx_hit:4'h5,
			default:'0});
		rdc("vec_rx", OFS_VEC, 32'h509);
		pe_u.pulse(cif_evt_t'{tx_done:1'b1, tx_idx:3'h7, default:'0});
		rdc("vec_prio", OFS_VEC, 32'h509);
		acc(1'b1, OFS_INTF, 32'hFD, 4'hF);
		rdc("vec_tx", OFS_VEC, 32'h507);
		pe_u.set_err(cif_err_t'{tx_error_warning:1'b1, default:'0});
		pe_u.pulse(cif_evt_t'{wakeup:1'b1, overflow:1'b1,
			almost_full:1'b1, default:'0});
		rdc("flags", OFS_INTF, 32'h56D);
		rdc("code_err", OFS_VEC, 32'h541);
		for (i = 0; i < 5; i++) begin
			acc(1'b1, OFS_INTF, ~(32'h1 << clr[i]), 4'hF);
			rdc("code", OFS_VEC, 32'h500 | code[i]);
		end
		$display("test codes done");
		// gating by enables, invalid flag, clear all
		pe_u.pulse(cif_evt_t'{tx_done:1'b1, tx_idx:3'h3, invalid:1'b1,
			default:'0});
		acc(1'b1, OFS_INTE, 32'hFE, 4'hF);
		rdc("vec_mask", OFS_VEC, 32'h540);
		acc(1'b1, OFS_INTE, 32'h1, 4'hF);
		rdc("vec_unmask", OFS_VEC, 32'h503);
		rdc("flags_ivr", OFS_INTF, 32'h581);
		acc(1'b1, OFS_INTF, 32'h0, 4'hF);
		rdc("flags_clr", OFS_INTF, 32'h500);
		$display("test gating done");
		give_verdict();
	end
endmodule : cif_status_tb
